// ---- core/ccpis_pin_filter.sv ----
// Two-flop synchroniser and run-length glitch filter for the port pins.
// Assumes asynchronous pins; output is valid one clock after ready_o goes high.
`timescale 1ns/10ps
module ccpis_pin_filter #(
    parameter int W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] filt_o,
    output logic ready_o
);
    import ccpis_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0][CCPIS_FILT_LEN-1:0] hist;
        logic [W-1:0] filt;
        logic [CCPIS_FILT_LEN+1:0] fill;
    } ccpis_filt_s;

    ccpis_filt_s cur;
    ccpis_filt_s next;

    always_comb begin
        next = cur;
        next.s1 = pin_i;
        next.s2 = cur.s1;
        next.fill = {cur.fill[CCPIS_FILT_LEN:0], 1'b1};
        for (int i = 0; i < W; i++) begin
            next.hist[i] = {cur.hist[i][CCPIS_FILT_LEN-2:0], cur.s2[i]};
            // Level moves only after a full run of equal samples
            if (&cur.hist[i]) begin
                next.filt[i] = 1'b1;
            end else if (~|cur.hist[i]) begin
                next.filt[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur <= '{filt: '1, default: '0};
        end else begin
            cur <= next;
        end
    end

    assign filt_o = cur.filt;
    assign ready_o = cur.fill[CCPIS_FILT_LEN+1];
endmodule // ccpis_pin_filter

// ---- core/ccpis_pkg.sv ----
// Shared constants, types and word-map decoding for the control port slave.
// Assumes one link clock domain for the pins and one core clock domain.
package ccpis_pkg;
    // Fixed part of the 7-bit slave address; straps fill the two low bits
    localparam logic [4:0] CCPIS_ADDR_FIXED = 5'h0E;
    localparam int CCPIS_FILT_LEN = 3;
    localparam logic [1:0] CCPIS_LATCH_PULSES = 2'h3;
    localparam logic [15:0] CCPIS_SUB_MAX = 16'h002F;
    localparam logic [15:0] CCPIS_LEN4_END = 16'h0007;
    localparam logic [15:0] CCPIS_LEN6_SUB = 16'h0008;
    localparam logic [15:0] CCPIS_LEN1_END = 16'h001F;
    localparam logic [15:0] CCPIS_LEN2_END = 16'h0027;
    localparam logic [2:0] CCPIS_LEN_A = 3'h4;
    localparam logic [2:0] CCPIS_LEN_B = 3'h6;
    localparam logic [2:0] CCPIS_LEN_C = 3'h1;
    localparam logic [2:0] CCPIS_LEN_D = 3'h2;
    localparam logic [2:0] CCPIS_LEN_E = 3'h5;
    localparam int CCPIS_MEM_DEPTH = 48;
    localparam int CCPIS_IDX_W = 6;
    localparam int CCPIS_WORD_W = 48;
    localparam logic [5:0] CCPIS_TOP_SHIFT = 6'h28;

    typedef enum logic [4:0] {
        CCPIS_IDLE = 5'h01,
        CCPIS_RX = 5'h02,
        CCPIS_ACK = 5'h04,
        CCPIS_TX = 5'h08,
        CCPIS_TXACK = 5'h10
    } ccpis_state_e;

    function automatic logic ccpis_sub_valid(input logic [15:0] sub);
        return sub <= CCPIS_SUB_MAX;
    endfunction

    function automatic logic [2:0] ccpis_word_len(input logic [15:0] sub);
        if (sub <= CCPIS_LEN4_END) return CCPIS_LEN_A;
        if (sub == CCPIS_LEN6_SUB) return CCPIS_LEN_B;
        if (sub <= CCPIS_LEN1_END) return CCPIS_LEN_C;
        if (sub <= CCPIS_LEN2_END) return CCPIS_LEN_D;
        return CCPIS_LEN_E;
    endfunction

    // Bit offset of byte k in a word stored first byte at the top
    function automatic logic [5:0] ccpis_byte_shift(input logic [2:0] k);
        return CCPIS_TOP_SHIFT - {k, 3'h0};
    endfunction

    function automatic logic [7:0] ccpis_byte_get(input logic [47:0] w,
                                                  input logic [2:0] k);
        return 8'(w >> ccpis_byte_shift(k));
    endfunction

    function automatic logic [47:0] ccpis_byte_put(input logic [47:0] w,
                                                   input logic [2:0] k,
                                                   input logic [7:0] b);
        return (w & ~(48'h0000000000FF << ccpis_byte_shift(k)))
            | (48'(b) << ccpis_byte_shift(k));
    endfunction
endpackage

// ---- core/ccpis_reg_store.sv ----
// Core-side register and parameter store, served by a toggle handshake.
// Assumes request fields stay stable from toggle until the answer toggle.
`timescale 1ns/10ps
module ccpis_reg_store (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_tog_i,
    input wire logic req_we_i,
    input wire logic [ccpis_pkg::CCPIS_IDX_W-1:0] req_idx_i,
    input wire logic [ccpis_pkg::CCPIS_WORD_W-1:0] req_data_i,
    output logic ack_tog_o,
    output logic [ccpis_pkg::CCPIS_WORD_W-1:0] rdata_o
);
    import ccpis_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic ack;
        logic [CCPIS_WORD_W-1:0] rdata;
    } ccpis_store_s;

    ccpis_store_s cur;
    ccpis_store_s next;
    logic [CCPIS_WORD_W-1:0] mem [CCPIS_MEM_DEPTH];
    logic req_ev;

    always_comb begin
        next = cur;
        next.s1 = req_tog_i;
        next.s2 = cur.s1;
        next.s3 = cur.s2;
        req_ev = cur.s2 ^ cur.s3;
        if (req_ev) begin
            next.ack = cur.s2;
            if (!req_we_i) begin
                next.rdata = mem[req_idx_i];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur <= '0;
            for (int i = 0; i < CCPIS_MEM_DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else begin
            cur <= next;
            if (req_ev && req_we_i) begin
                mem[req_idx_i] <= req_data_i;
            end
        end
    end

    assign ack_tog_o = cur.ack;
    assign rdata_o = cur.rdata;
endmodule // ccpis_reg_store

// ---- core/ccpis_slave.sv ----
// Control port slave: I2C engine on the link clock, store on the core clock.
// Assumes the link clock oversamples SCL at least 16 times per bit.
// How it works
// - I2C after reset; three latch lows select SPI
// - Straps become latch and data in SPI; the code has no SPI datapath, SPI mode only holds the I2C engine idle
// - Address byte, two subaddress bytes, then data
// - Slave only, never starts a transfer
// - Address 0111 0 plus two strap bits
// - Address byte LSB one reads, zero writes
// - Writes advance subaddress after each word
// - Word length from subaddress, one to six
// - Start and stop are SDA edges, SCL high
// - Match acks on ninth clock, else idle
// - Stray stop returns to idle, stray start restarts address receive
// - Invalid subaddress: no ack, back to idle
// - Read past top repeats top register
// - Write past top: discard, nack, idle
// - Every location readable and writable, burst too
// - SPI mode holds until full reset
// - Reads advance subaddress per word length
`timescale 1ns/10ps
module ccpis_slave (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    input wire logic ctrl_serial_clock_i,
    input wire logic ctrl_serial_out_i,
    output logic ctrl_serial_out_o,
    output logic ctrl_serial_out_oe_o,
    input wire logic latch_select_i,
    input wire logic ctrl_serial_in_i,
    output logic spi_mode_o
);
    import ccpis_pkg::*;

    typedef struct packed {
        ccpis_state_e st;
        logic [2:0] bitcnt;
        logic [7:0] sh;
        logic [1:0] byte_idx;
        logic rw;
        logic drv;
        logic mack;
        logic [7:0] sub_hi;
        logic [15:0] addr;
        logic [2:0] bytecnt;
        logic over;
        logic [47:0] wdata;
        logic [47:0] wr_word;
        logic [5:0] wr_idx;
        logic wr_pend;
        logic rd_pend;
        logic req_tog;
        logic req_we;
        logic [5:0] req_idx;
        logic [47:0] req_data;
        logic inflight;
        logic ack_s1;
        logic ack_s2;
        logic [47:0] rd_word;
        logic oe;
        logic prev_scl;
        logic prev_sda;
        logic prev_latch;
        logic evt_ok;
        logic [1:0] latch_cnt;
        logic spi;
    } ccpis_link_s;

    ccpis_link_s cur;
    ccpis_link_s next;
    logic [1:0] lrst_sync;
    logic link_rst;
    logic [3:0] filt;
    logic filt_rdy;
    logic f_scl, f_sda, f_din, f_latch;
    logic store_ack;
    logic [47:0] store_rdata;
    logic scl_rise, scl_fall, start_ev, stop_ev, latch_fall;
    logic byte_done, addr_match, sub_ok, last_byte, do_load;
    logic [7:0] rx_byte;
    logic [7:0] ld_byte;
    logic [47:0] wr_next;
    logic [15:0] sub_full;

    // Link reset: asserts at once, releases on the link clock
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lrst_sync <= 2'h3;
        end else begin
            lrst_sync <= {lrst_sync[0], 1'b0};
        end
    end
    assign link_rst = lrst_sync[1];

    ccpis_pin_filter #(.W(4)) u_filt (
        .clk_i(link_clk_i),
        .rst_i(link_rst),
        .pin_i({latch_select_i, ctrl_serial_in_i, ctrl_serial_out_i,
                ctrl_serial_clock_i}),
        .filt_o(filt),
        .ready_o(filt_rdy)
    );
    assign {f_latch, f_din, f_sda, f_scl} = filt;

    ccpis_reg_store u_store (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .req_tog_i(cur.req_tog),
        .req_we_i(cur.req_we),
        .req_idx_i(cur.req_idx),
        .req_data_i(cur.req_data),
        .ack_tog_o(store_ack),
        .rdata_o(store_rdata)
    );

    always_comb begin
        next = cur;
        next.prev_scl = f_scl;
        next.prev_sda = f_sda;
        next.prev_latch = f_latch;
        next.evt_ok = filt_rdy;
        scl_rise = cur.evt_ok && f_scl && !cur.prev_scl;
        scl_fall = cur.evt_ok && !f_scl && cur.prev_scl;
        start_ev = cur.evt_ok && f_scl && cur.prev_scl
            && !f_sda && cur.prev_sda;
        stop_ev = cur.evt_ok && f_scl && cur.prev_scl
            && f_sda && !cur.prev_sda;
        latch_fall = cur.evt_ok && !f_latch && cur.prev_latch;
        rx_byte = {cur.sh[6:0], f_sda};
        byte_done = cur.st == CCPIS_RX && scl_rise && cur.bitcnt == 3'h7;
        // Strap pins serve as address bits only while in I2C mode
        addr_match = rx_byte[7:1] == {CCPIS_ADDR_FIXED, f_latch, f_din};
        sub_full = {cur.sub_hi, rx_byte};
        sub_ok = ccpis_sub_valid(sub_full);
        last_byte = cur.bytecnt == ccpis_word_len(cur.addr) - 3'h1;
        ld_byte = ccpis_byte_get(cur.rd_word, cur.bytecnt);
        wr_next = ccpis_byte_put(cur.wdata, cur.bytecnt, rx_byte);
        do_load = 1'b0;

        // Mode select: three latch lows, sticky until reset
        if (!cur.spi && latch_fall) begin
            if (cur.latch_cnt == CCPIS_LATCH_PULSES - 2'h1) begin
                next.spi = 1'b1;
            end else begin
                next.latch_cnt = cur.latch_cnt + 2'h1;
            end
        end

        // Store handshake: writes before read prefetch
        next.ack_s1 = store_ack;
        next.ack_s2 = cur.ack_s1;
        if (cur.inflight) begin
            if (cur.req_tog == cur.ack_s2) begin
                next.inflight = 1'b0;
                if (!cur.req_we) begin
                    next.rd_word = store_rdata;
                end
            end
        end else if (cur.wr_pend) begin
            next.wr_pend = 1'b0;
            next.req_we = 1'b1;
            next.req_idx = cur.wr_idx;
            next.req_data = cur.wr_word;
            next.req_tog = !cur.req_tog;
            next.inflight = 1'b1;
        end else if (cur.rd_pend) begin
            next.rd_pend = 1'b0;
            next.req_we = 1'b0;
            next.req_idx = cur.addr[5:0];
            next.req_tog = !cur.req_tog;
            next.inflight = 1'b1;
        end

        if (cur.spi) begin
            next.st = CCPIS_IDLE;
            next.oe = 1'b0;
        end else if (start_ev) begin
            next.st = CCPIS_RX;
            next.bitcnt = 3'h0;
            next.byte_idx = 2'h0;
            next.oe = 1'b0;
            next.drv = 1'b0;
        end else if (stop_ev) begin
            next.st = CCPIS_IDLE;
            next.oe = 1'b0;
        end else begin
            case (cur.st)
                CCPIS_IDLE: begin
                    next.oe = 1'b0;
                end
                CCPIS_RX: begin
                    if (scl_rise) begin
                        next.sh = rx_byte;
                        next.bitcnt = cur.bitcnt + 3'h1;
                    end
                    if (byte_done) begin
                        next.st = CCPIS_ACK;
                        next.drv = 1'b0;
                        if (cur.byte_idx != 2'h3) begin
                            next.byte_idx = cur.byte_idx + 2'h1;
                        end
                        case (cur.byte_idx)
                            2'h0: begin
                                next.rw = rx_byte[0];
                                if (!addr_match) begin
                                    next.st = CCPIS_IDLE;
                                end
                            end
                            2'h1: begin
                                next.sub_hi = rx_byte;
                            end
                            2'h2: begin
                                if (sub_ok) begin
                                    next.addr = sub_full;
                                    next.bytecnt = 3'h0;
                                    next.over = 1'b0;
                                    next.rd_pend = 1'b1;
                                end else begin
                                    next.st = CCPIS_IDLE;
                                end
                            end
                            default: begin
                                if (cur.over) begin
                                    next.st = CCPIS_IDLE;
                                end else if (last_byte) begin
                                    next.wr_word = wr_next;
                                    next.wr_idx = cur.addr[5:0];
                                    next.wr_pend = 1'b1;
                                    next.bytecnt = 3'h0;
                                    if (cur.addr == CCPIS_SUB_MAX) begin
                                        next.over = 1'b1;
                                    end else begin
                                        next.addr = cur.addr + 16'h1;
                                    end
                                end else begin
                                    next.wdata = wr_next;
                                    next.bytecnt = cur.bytecnt + 3'h1;
                                end
                            end
                        endcase
                    end
                end
                CCPIS_ACK: begin
                    if (scl_fall) begin
                        if (!cur.drv) begin
                            next.oe = 1'b1;
                            next.drv = 1'b1;
                        end else begin
                            next.oe = 1'b0;
                            next.drv = 1'b0;
                            next.bitcnt = 3'h0;
                            next.st = CCPIS_RX;
                            do_load = cur.rw;
                        end
                    end
                end
                CCPIS_TX: begin
                    if (scl_fall) begin
                        if (cur.bitcnt == 3'h7) begin
                            next.oe = 1'b0;
                            next.st = CCPIS_TXACK;
                            next.mack = 1'b0;
                        end else begin
                            next.bitcnt = cur.bitcnt + 3'h1;
                            next.sh = {cur.sh[6:0], 1'b0};
                            next.oe = !cur.sh[6];
                        end
                    end
                end
                CCPIS_TXACK: begin
                    if (scl_rise) begin
                        if (f_sda) begin
                            next.st = CCPIS_IDLE;
                        end else begin
                            next.mack = 1'b1;
                        end
                    end
                    do_load = scl_fall && cur.mack;
                end
                default: begin
                    next.st = CCPIS_IDLE;
                    next.oe = 1'b0;
                end
            endcase
        end

        // Next read byte goes out on an SCL fall
        if (do_load) begin
            next.st = CCPIS_TX;
            next.sh = ld_byte;
            next.oe = !ld_byte[7];
            next.bitcnt = 3'h0;
            if (last_byte) begin
                next.bytecnt = 3'h0;
                if (cur.addr != CCPIS_SUB_MAX) begin
                    next.addr = cur.addr + 16'h1;
                    next.rd_pend = 1'b1;
                end
            end else begin
                next.bytecnt = cur.bytecnt + 3'h1;
            end
        end
    end

    always_ff @(posedge link_clk_i or posedge link_rst) begin
        if (link_rst) begin
            cur <= '{st: CCPIS_IDLE, prev_scl: 1'b1, prev_sda: 1'b1,
                     prev_latch: 1'b1, default: '0};
        end else begin
            cur <= next;
        end
    end

    // Open-drain: the data level is always low, only the enable moves
    assign ctrl_serial_out_o = 1'b0;
    assign ctrl_serial_out_oe_o = cur.oe;
    assign spi_mode_o = cur.spi;

    default clocking cb @(posedge link_clk_i); endclocking
    default disable iff (link_rst);

    AST_SPI_STICKY: assert property (cur.spi |=> cur.spi)
        else $error("spi mode dropped");
    AST_SPI_ENTRY: assert property (!cur.spi && latch_fall
        && cur.latch_cnt == 2'h2 |=> cur.spi)
        else $error("spi mode not entered on third latch low");
    AST_SPI_QUIET: assert property (cur.spi
        |=> !ctrl_serial_out_oe_o)
        else $error("sda driven in spi mode");
    AST_IDLE_QUIET: assert property (cur.st == CCPIS_IDLE
        && !start_ev |=> !ctrl_serial_out_oe_o)
        else $error("sda driven while idle");
    AST_OE_SCL_LOW: assert property ($rose(ctrl_serial_out_oe_o)
        |-> !f_scl && $past(scl_fall))
        else $error("sda pulled outside scl fall");
    AST_START_RX: assert property (start_ev && !cur.spi
        |=> cur.st == CCPIS_RX && cur.bitcnt == 3'h0)
        else $error("start not taken");
    AST_STOP_IDLE: assert property (stop_ev && !start_ev
        |=> cur.st == CCPIS_IDLE)
        else $error("stop did not idle");
    AST_ADDR_MISS: assert property (byte_done
        && cur.byte_idx == 2'h0 && !addr_match && !cur.spi
        |=> cur.st == CCPIS_IDLE ##1 !ctrl_serial_out_oe_o)
        else $error("foreign address not ignored");
    AST_ADDR_ACK: assert property (byte_done
        && cur.byte_idx == 2'h0 && addr_match && !cur.spi
        |=> cur.st == CCPIS_ACK && !cur.drv)
        else $error("own address not acked");
    AST_ACK_PULL: assert property (cur.st == CCPIS_ACK
        && !cur.drv && scl_fall && !cur.spi |=> ctrl_serial_out_oe_o)
        else $error("ack not driven on scl fall");
    AST_BAD_SUB: assert property (byte_done
        && cur.byte_idx == 2'h2 && !sub_ok && !cur.spi
        |=> cur.st == CCPIS_IDLE)
        else $error("invalid subaddress acked");
    AST_WR_OVER: assert property (byte_done
        && cur.byte_idx == 2'h3 && cur.over && !cur.spi
        |=> cur.st == CCPIS_IDLE)
        else $error("write overrun acked");
    AST_WR_INC: assert property (byte_done && !cur.over
        && cur.byte_idx == 2'h3 && last_byte
        && cur.addr != CCPIS_SUB_MAX && !cur.spi
        |=> cur.addr == $past(cur.addr) + 16'h1 && cur.wr_pend)
        else $error("write word boundary missed");
    AST_RD_TOP: assert property (do_load
        && cur.addr == CCPIS_SUB_MAX |=> cur.addr == CCPIS_SUB_MAX)
        else $error("read moved past top");

    COV_WRITE_WORD: cover property (byte_done && cur.byte_idx == 2'h3
        && last_byte && !cur.over);
    COV_READ_BYTE: cover property (cur.st == CCPIS_TXACK && cur.mack);
    COV_SPI: cover property ($rose(cur.spi));
    COV_OVERRUN: cover property (cur.over && byte_done);
endmodule // ccpis_slave

// ---- verification/ccpis_i2c_master.sv ----
// I2C master model: drives SCL and pulls SDA, samples the wired level.
// Assumes pull-ups; the bench forms the wired SDA level.
`timescale 1ns/10ps
module ccpis_i2c_master (
    output logic scl_o,
    output logic sda_o,
    input wire logic sda_i
);
    // Quarter bit; SCL high and low each just over 16 link cycles
    localparam int Q = 520;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic bit_x(input logic v, output logic s);
        #Q sda_o = v;
        #Q scl_o = 1'b1;
        #Q s = sda_i;
        #Q scl_o = 1'b0;
    endtask
    // Start or repeated start
    task automatic start();
        #Q sda_o = 1'b1;
        #Q scl_o = 1'b1;
        #(2*Q) sda_o = 1'b0;
        #(2*Q) scl_o = 1'b0;
    endtask
    task automatic stop();
        #Q sda_o = 1'b0;
        #Q scl_o = 1'b1;
        #(2*Q) sda_o = 1'b1;
        #(2*Q);
    endtask
    // MSB first, ack seen on the ninth clock
    task automatic put(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(b[i], s);
        bit_x(1'b1, s);
        ack = !s;
    endtask
    // Ack each byte, release SDA after the last
    task automatic get(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            b[i] = s;
        end
        bit_x(last, s);
    endtask
endmodule // ccpis_i2c_master

// ---- verification/ccpis_slave_test.sv ----
// Bench for the control port slave: addresses, bursts, overruns, mode.
// Assumes the master model ccpis_i2c_master on the pins.
`timescale 1ns/10ps
module ccpis_slave_test;
    import ccpis_pkg::*;
    localparam logic [7:0] AW = 8'h76;
    logic clk_i = 1'b0;
    logic link_clk = 1'b0;
    logic rst_i = 1'b1;
    logic hi = 1'b0;
    logic lo = 1'b0;
    logic scl, sda_m, sda_out, sda_oe, spi;
    wire logic sda = sda_m & !(sda_oe & !sda_out);
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    logic ack;
    logic [7:0] rd;
    always #5 clk_i = ~clk_i;
    initial #3 forever #32 link_clk = ~link_clk;
    ccpis_slave ccpis_slave_inst (
        .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk),
        .ctrl_serial_clock_i(scl), .ctrl_serial_out_i(sda),
        .ctrl_serial_out_o(sda_out), .ctrl_serial_out_oe_o(sda_oe),
        .latch_select_i(hi), .ctrl_serial_in_i(lo), .spi_mode_o(spi)
    );
    ccpis_i2c_master ccpis_i2c_master_inst (
        .scl_o(scl), .sda_o(sda_m), .sda_i(sda)
    );
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        if (n_fail == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(sda_oe) if (scl === 1'b1 && rst_i === 1'b0) begin
        n_fail++;
        $display("[ERR] %0t SDA moved with SCL high", $time);
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 110000) begin
            n_fail++;
            $display("[ERR] %0t timeout", $time);
            summarize();
        end
    end
    task automatic do_reset();
        @(negedge clk_i) rst_i = 1'b1;
        repeat (8) @(posedge link_clk);
        @(negedge clk_i) rst_i = 1'b0;
        repeat (12) @(posedge link_clk);
        chk({6'h0, spi, sda_oe}, 8'h00);
    endtask
    task automatic adr(input logic [7:0] a, input logic [7:0] exp);
        ccpis_i2c_master_inst.start();
        ccpis_i2c_master_inst.put(a, ack);
        chk(8'(ack), exp);
    endtask
    task automatic head(input logic [15:0] sub, input logic [7:0] exp);
        adr(AW, 8'h01);
        ccpis_i2c_master_inst.put(sub[15:8], ack);
        chk(8'(ack), 8'h01);
        ccpis_i2c_master_inst.put(sub[7:0], ack);
        chk(8'(ack), exp);
    endtask
    task automatic wr(input logic [15:0] sub, input logic [7:0] d[$],
                      input int n_ok);
        head(sub, 8'h01);
        foreach (d[i]) begin
            ccpis_i2c_master_inst.put(d[i], ack);
            chk(8'(ack), 8'(i < n_ok));
        end
        ccpis_i2c_master_inst.stop();
    endtask
    task automatic rdc(input logic [15:0] sub, input logic [7:0] e[$]);
        head(sub, 8'h01);
        adr(AW | 8'h01, 8'h01);
        foreach (e[i]) begin
            ccpis_i2c_master_inst.get(i == e.size() - 1, rd);
            chk(rd, e[i]);
        end
        ccpis_i2c_master_inst.stop();
    endtask
    task automatic t_addr();
        for (int s = 0; s < 4; s++) begin
            @(negedge clk_i) {hi, lo} = 2'(s);
            #2000;
            adr(8'h70 | 8'(s << 1), 8'h01);
            ccpis_i2c_master_inst.stop();
        end
        adr(8'h70, 8'h00);
        ccpis_i2c_master_inst.stop();
    endtask
    task automatic t_invalid();
        head(16'h0030, 8'h00);
        ccpis_i2c_master_inst.put(8'h55, ack);
        chk(8'(ack), 8'h00);
        ccpis_i2c_master_inst.stop();
    endtask
    task automatic t_spi();
        for (int k = 0; k < 3; k++) begin
            chk(8'(spi), 8'h00);
            @(negedge clk_i) hi = 1'b0;
            #1000;
            @(negedge clk_i) hi = 1'b1;
            #1000;
        end
        chk(8'(spi), 8'h01);
        adr(AW, 8'h00);
        ccpis_i2c_master_inst.stop();
        chk(8'(spi), 8'h01);
        do_reset();
    endtask
    initial begin
        do_reset();
        t_addr();
        wr(16'h0027, '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6}, 7);
        rdc(16'h0028, '{8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'h00});
        t_invalid();
        wr(16'h002F, '{8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB5}, 5);
        rdc(16'h002F, '{8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB0});
        t_spi();
        summarize();
    end
endmodule // ccpis_slave_test
